//--- hw/upp_top.v
`include "upp_consts.vh"

module upp_fifo #(
  parameter WIDTH = `UPP_DATA_W,
  parameter DEPTH = `UPP_FIFO_DEPTH,
  parameter AW    = `UPP_FIFO_AW
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             wr_valid,
  output reg              wr_ready,
  input  wire [WIDTH-1:0] wr_data,
  output reg              rd_valid,
  input  wire             rd_ready,
  output wire [WIDTH-1:0] rd_data
);
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wptr_q;
  reg  [AW-1:0]    rptr_q;
  reg  [AW:0]      cnt_q;
  wire             push;
  wire             pop;
  wire [AW:0]      cnt_d;

  assign push    = wr_valid & wr_ready;
  assign pop     = rd_valid & rd_ready;
  assign cnt_d   = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign rd_data = mem_q[rptr_q];

  always @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= wr_data;
    end
  end

  // Flags registered from the next count so both ends see flop outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_q   <= {AW{1'b0}};
      rptr_q   <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == DEPTH - 1) ? {AW{1'b0}} : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == DEPTH - 1) ? {AW{1'b0}} : rptr_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      wr_ready <= (cnt_d != DEPTH);
      rd_valid <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule

module upp_top #(
  parameter DW = `UPP_DATA_W
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire          mux_mode,
  input  wire          self_powered,
  input  wire          cs_low,
  input  wire          rd_low,
  input  wire          wr_low,
  input  wire          ale,
  input  wire          phase_select,
  input  wire [DW-1:0] data_in,
  output reg  [DW-1:0] data_out,
  output reg           data_oe,
  input  wire          dma_enable,
  input  wire          dma_burst,
  output reg           dma_request_out,
  input  wire          dma_grant_low,
  input  wire          transfer_end_low,
  input  wire          suspend_in,
  output reg           suspend_out,
  output reg           suspend_oe,
  output reg           irq_out,
  output reg           irq_oe,
  output reg           activity_lamp_low,
  output reg           activity_lamp_oe,
  input  wire          usb_suspended,
  input  wire          usb_activity,
  input  wire          irq_pending,
  input  wire          irq_enable,
  output reg           cmd_valid,
  output reg  [DW-1:0] cmd_byte,
  input  wire [DW-1:0] rsp_byte,
  output reg           rsp_taken,
  output wire          buf_valid,
  input  wire          buf_ready,
  output wire [DW-1:0] buf_data,
  output reg           vbus_present,
  output reg           wakeup_req,
  output reg           dma_ended
);
  reg           rd_prev_q;
  reg           wr_prev_q;
  reg           addr_phase_q;
  reg           grant_seen_q;
  reg           dma_en_prev_q;
  reg  [DW-1:0] push_data_q;
  reg           push_q;
  wire          sel;
  wire          dma_acc;
  wire          wr_start;
  wire          rd_start;
  wire          cmd_phase;
  wire          fifo_ready;
  wire          fifo_valid;
  wire [DW-1:0] status;

  assign sel      = ~cs_low | dma_acc;
  assign dma_acc  = ~dma_grant_low & dma_enable;
  assign wr_start = sel & wr_prev_q & ~wr_low;
  assign rd_start = sel & rd_prev_q & ~rd_low;
  assign cmd_phase = dma_acc ? 1'b0 :
                     (mux_mode ? addr_phase_q : phase_select);

  assign status = {2'b00, irq_oe, dma_ended, ~fifo_valid, ~fifo_ready,
                   usb_suspended, vbus_present};

  upp_fifo #(
    .WIDTH (DW),
    .DEPTH (`UPP_FIFO_DEPTH),
    .AW    (`UPP_FIFO_AW)
  ) u_in_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wr_valid (push_q),
    .wr_ready (fifo_ready),
    .wr_data  (push_data_q),
    .rd_valid (fifo_valid),
    .rd_ready (buf_ready),
    .rd_data  (buf_data)
  );
  assign buf_valid = fifo_valid;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_prev_q         <= 1'b1;
      wr_prev_q         <= 1'b1;
      addr_phase_q      <= 1'b1;
      grant_seen_q      <= 1'b0;
      dma_en_prev_q     <= 1'b0;
      push_data_q       <= `UPP_RESET_BYTE;
      push_q            <= 1'b0;
      data_out          <= `UPP_RESET_BYTE;
      data_oe           <= 1'b0;
      dma_request_out   <= 1'b0;
      suspend_out       <= 1'b0;
      suspend_oe        <= 1'b0;
      irq_out           <= 1'b0;
      irq_oe            <= 1'b0;
      activity_lamp_low <= 1'b0;
      activity_lamp_oe  <= 1'b0;
      cmd_valid         <= 1'b0;
      cmd_byte          <= `UPP_RESET_BYTE;
      rsp_taken         <= 1'b0;
      vbus_present      <= 1'b0;
      wakeup_req        <= 1'b0;
      dma_ended         <= 1'b0;
    end else begin
      rd_prev_q     <= rd_low;
      wr_prev_q     <= wr_low;
      dma_en_prev_q <= dma_enable;
      cmd_valid     <= 1'b0;
      rsp_taken     <= 1'b0;
      push_q        <= 1'b0;
      // Latch applies only in multiplexed mode; addr_phase_q holds its value otherwise
      if (mux_mode && ale) begin
        addr_phase_q <= data_in[`UPP_ADDR_PHASE_B];
      end
      if (wr_start && cmd_phase) begin
        cmd_valid <= 1'b1;
        cmd_byte  <= data_in;
      end
      // Full buffer drops the byte; DMA is already throttled by request
      if (wr_start && !cmd_phase && fifo_ready) begin
        push_q      <= 1'b1;
        push_data_q <= data_in;
      end
      if (rd_start) begin
        data_out  <= cmd_phase ? status : rsp_byte;
        rsp_taken <= ~cmd_phase;
      end
      data_oe <= sel & ~rd_low;
      // Transfer end and bus sense share a pin; mode picks the meaning
      if (self_powered) begin
        vbus_present <= transfer_end_low;
      end else begin
        vbus_present <= 1'b1;
      end
      // Set wins over the re-arm so an end seen on enable is not lost
      if (!self_powered && !transfer_end_low && dma_enable) begin
        dma_ended <= 1'b1;
      end else if (dma_enable && !dma_en_prev_q) begin
        dma_ended <= 1'b0;
      end
      if (!dma_enable || dma_grant_low) begin
        grant_seen_q <= 1'b0;
      end else if (!dma_burst) begin
        grant_seen_q <= 1'b1;
      end
      dma_request_out <= dma_enable & ~dma_ended & fifo_ready & ~grant_seen_q
                         & (self_powered | transfer_end_low);
      suspend_oe       <= usb_suspended;
      wakeup_req       <= ~usb_suspended & ~suspend_oe & ~suspend_in;
      activity_lamp_oe <= usb_activity;
      irq_oe           <= irq_pending & irq_enable;
    end
  end
endmodule

//--- hw/upp_consts.vh
`ifndef UPP_CONSTS_VH
`define UPP_CONSTS_VH

`define UPP_DATA_W       8
`define UPP_FIFO_DEPTH   32
`define UPP_FIFO_AW      5
`define UPP_ADDR_PHASE_B 0
`define UPP_ST_VBUS_B    0
`define UPP_ST_SUSP_B    1
`define UPP_ST_FULL_B    2
`define UPP_ST_EMPTY_B   3
`define UPP_ST_DMAEND_B  4
`define UPP_ST_IRQ_B     5
`define UPP_RESET_BYTE   8'h00
`endif

//--- testbench/upp_chk.sv
module upp_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_low,
  input wire logic rd_low,
  input wire logic wr_low,
  input wire logic mux_mode,
  input wire logic phase_select,
  input wire logic data_oe,
  input wire logic dma_enable,
  input wire logic dma_burst,
  input wire logic dma_grant_low,
  input wire logic cmd_valid,
  input wire logic dma_request_out,
  input wire logic dma_ended,
  input wire logic transfer_end_low,
  input wire logic self_powered,
  input wire logic vbus_present,
  input wire logic usb_suspended,
  input wire logic suspend_in,
  input wire logic suspend_out,
  input wire logic suspend_oe,
  input wire logic wakeup_req,
  input wire logic usb_activity,
  input wire logic activity_lamp_low,
  input wire logic activity_lamp_oe,
  input wire logic irq_pending,
  input wire logic irq_enable,
  input wire logic irq_out,
  input wire logic irq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_read_select: assert property (data_oe |->
    $past(!rd_low && (!cs_low || dma_enable && !dma_grant_low))) else $error("unselected drive");
  chk_cmd_phase: assert property (cmd_valid |->
    $past(!cs_low && !wr_low && (mux_mode || phase_select)) && $past(wr_low, 2))
    else $error("bad command");
  chk_end_stops: assert property ($past(dma_ended) && dma_ended |-> !dma_request_out)
    else $error("request after end");
  chk_end_sets: assert property (dma_enable && $past(dma_enable) && !transfer_end_low
    && !self_powered |=> dma_ended) else $error("end missed");
  chk_vbus_sense: assert property (!$past(sys_rst) && $past(self_powered) |->
    vbus_present == $past(transfer_end_low)) else $error("power sense");
  chk_susp_drive: assert property (usb_suspended && !sys_rst ##1 usb_suspended |->
    suspend_oe) else $error("suspend idle");
  chk_lamp_track: assert property (usb_activity && !sys_rst ##1 usb_activity |->
    activity_lamp_oe) else $error("lamp idle");
  chk_irq_hold: assert property ((irq_pending && irq_enable && !sys_rst) [*2] |->
    irq_oe) else $error("irq idle");
  chk_wake_req: assert property (!$past(sys_rst) |->
    wakeup_req == $past(!usb_suspended && !suspend_oe && !suspend_in))
    else $error("wakeup request");
  chk_req_single: assert property (dma_enable && !dma_burst && !dma_grant_low && !sys_rst
    |-> ##2 !dma_request_out) else $error("single request held");
  chk_drain_low: assert property (!suspend_out && !irq_out && !activity_lamp_low)
    else $error("drain level");
endmodule

bind upp_top upp_chk u_chk (.*);

//--- testbench/upp_host.sv
module upp_host (
  input  wire logic       clk,
  input  wire logic       mux_mode,
  output logic            cs_low = 1'b1,
  output logic            rd_low = 1'b1,
  output logic            wr_low = 1'b1,
  output logic            ale = 1'b0,
  output logic            phase_select = 1'b1,
  output logic            dma_grant_low = 1'b1,
  output logic      [7:0] data_in = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Who: 0 nobody, 1 chip select, 2 DMA grant
  task acc(input int who, input bit rd, input bit ph, input logic [7:0] d);
    @(posedge clk);
    if (mux_mode) begin
      ale <= 1'b1;
      data_in <= {7'h00, ph};
      @(posedge clk);
      ale <= 1'b0;
    end
    phase_select <= mux_mode | ph;
    cs_low <= who != 1;
    dma_grant_low <= who != 2;
    data_in <= rd ? ~data_in : d;
    if (rd) rd_low <= 1'b0;
    else wr_low <= 1'b0;
    @(posedge clk);
    {cs_low, rd_low, wr_low, dma_grant_low} <= 4'hf;
    // Released bus must not look like held data
    data_in <= ~d;
  endtask
endmodule

//--- testbench/upp_top_bench.sv
module upp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, mux_mode = 1'b0, self_powered = 1'b0, wake_low = 1'b0;
  logic dma_enable = 1'b0, dma_burst = 1'b0, transfer_end_low = 1'b1, buf_ready = 1'b0;
  logic usb_suspended = 1'b0, usb_activity = 1'b0, irq_pending = 1'b0, irq_enable = 1'b0;
  logic [7:0] rsp_byte = 8'h00, d, data_in, data_out, cmd_byte, buf_data;
  logic cs_low, rd_low, wr_low, ale, phase_select, dma_grant_low, data_oe, dma_request_out;
  logic suspend_out, suspend_oe, irq_out, irq_oe, activity_lamp_low, activity_lamp_oe;
  logic cmd_valid, rsp_taken, buf_valid, vbus_present, wakeup_req, dma_ended;
  wire suspend_in = ~(suspend_oe | wake_low);
  int fail_count = 0, checks = 0, seed = 94498;
  logic [7:0] exp_q[$];
  upp_top u_dut (.*);
  upp_host u_host (.*);
  always #20 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask
  task print_verdict;
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    {usb_suspended, usb_activity, irq_pending, irq_enable, wake_low} <= 5'($random(seed));
    if (cmd_valid === 1'b1 || (buf_valid & buf_ready) === 1'b1)
      chk(cmd_valid ? cmd_byte : buf_data, exp_q.pop_front());
  end
  initial begin
    #400000;
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    dma_enable <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) mux_mode <= m[0];
      d = 8'($random(seed));
      exp_q.push_back(d);
      u_host.acc(1, 0, 1, d);
      u_host.acc(0, 0, 0, d);
      // One write past full, which must vanish
      for (int i = 0; i < 33; i++) begin
        d = 8'($random(seed));
        if (i < 32) exp_q.push_back(d);
        u_host.acc(2 - m, 0, 0, d);
      end
      u_host.acc(1, 1, 1, d);
      @(negedge clk) chk({6'h00, data_out[3:2]}, 8'h01);
      repeat (150) @(posedge clk) buf_ready <= 1'($random(seed));
      @(posedge clk) buf_ready <= 1'b0;
      u_host.acc(1, 1, 1, d);
      @(negedge clk) chk({6'h00, data_out[3:2]}, 8'h02);
      @(posedge clk) rsp_byte <= 8'($random(seed));
      u_host.acc(1, 1, 0, d);
      @(negedge clk) chk(data_out, rsp_byte);
      chk({7'h00, rsp_taken}, 8'h01);
      chk({7'h00, data_oe}, 8'h01);
    end
    @(posedge clk) transfer_end_low <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) chk({7'h00, dma_ended}, 8'h01);
    @(posedge clk) self_powered <= 1'b1;
    repeat (40) @(posedge clk) transfer_end_low <= 1'($random(seed));
    chk(8'(exp_q.size()), 8'h00);
    print_verdict;
  end
endmodule
